// >>> eeprom_port_regs.svh
/*
 * constants of the serial eeprom command port: field widths, opcodes,
 * address patterns, reset values and timing counts.
 * assumes a 10 MHz core clock sampling the serial pins.
 */
`ifndef EEPROM_PORT_REGS_SVH
`define EEPROM_PORT_REGS_SVH

`define OPC_READ        2'b10
`define OPC_WRITE       2'b01
`define OPC_MISC        2'b00
`define OPC_CLEAR       2'b11
`define MSB_ENABLE      2'b11
`define MSB_ALL         2'b01
`define MSB_DISABLE     2'b00
`define ADDR_ONES       8'hff
`define ADDR_ZERO       8'h00
`define PROT_RESET      8'hff
`define OPC_BITS        2
`define ADDR_BITS       8
`define DATA_BITS       16
`define CORE_CLK_HZ     10000000
`define PROG_TIME_MS    15
`define PROG_CYCLES     ((`PROG_TIME_MS * `CORE_CLK_HZ) / 1000)

`endif

// >>> eeprom_port_pkg.sv
/*
 * types of the serial eeprom command port.
 * assumes nothing of its surroundings.
 */
package eeprom_port_pkg;

    // pins facing the master, raw or synchronised
    typedef struct packed {
        logic chipSelect;
        logic serialClock;
        logic serialIn;
        logic protectRegSelect;
        logic programEnable;
    } pins_t;

    // decoded instruction
    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_READ,
        CMD_WRITE,
        CMD_WRITE_ENABLE,
        CMD_WRITE_ALL,
        CMD_WRITE_DISABLE,
        CMD_PROT_READ,
        CMD_PROT_ENABLE,
        CMD_PROT_CLEAR,
        CMD_PROT_WRITE,
        CMD_PROT_DISABLE
    } cmd_t;

endpackage

// >>> pin_sync.sv
/*
 * two-flop synchroniser for a group of pin inputs.
 * assumes the pins are asynchronous to clock.
 */
`timescale 1ns/10ps

module pin_sync
    import eeprom_port_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] nxt_meta;

    initial begin
        if (WIDTH < 1) $error("pin_sync: WIDTH must be positive");
    end

    // first stage is read only by the second
    always_comb begin
        nxt_meta = asyncIn;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            syncOut <= '0;
        end else begin
            meta_ff <= nxt_meta;
            syncOut <= meta_ff;
        end
    end

endmodule

// >>> serial_eeprom_command_port.sv
/*
 * device side of a 256 x 16 serial eeprom: frames cycles on chip select,
 * shifts in start bit, opcode, address and data on serial clock rises,
 * decodes ten instructions, drives read data and busy status.
 * assumes all pins are asynchronous and a much faster core clock.
 */
`timescale 1ns/10ps
`include "eeprom_port_regs.svh"

module serial_eeprom_command_port
    import eeprom_port_pkg::*;
#(
    parameter int DEPTH       = 256,
    parameter int WIDTH       = 16,
    parameter int PROG_CYCLES = `PROG_CYCLES
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic chipSelect,
    input  wire logic serialClock,
    input  wire logic serialIn,
    input  wire logic protectRegSelect,
    input  wire logic programEnable,
    output logic      serialOut,
    output logic      serialOutEn,
    output logic      busy
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_WAIT
    } state_t;

    initial begin
        if (DEPTH != 256 || WIDTH != 16 || PROG_CYCLES < 1 ||
            PROG_CYCLES > 24'hff_ffff)
            $error("serial_eeprom_command_port: unsupported parameters");
    end

    pins_t pinsRaw;
    pins_t pins;
    assign pinsRaw = '{chipSelect, serialClock, serialIn,
                       protectRegSelect, programEnable};

    pin_sync #(.WIDTH(5)) uSync (
        .clock   (clock),
        .rst_b   (rst_b),
        .asyncIn (pinsRaw),
        .syncOut (pins)
    );

    // edge history for select and serial clock
    logic csDly_ff;
    logic skDly_ff;
    logic csRise;
    logic csFall;
    logic skRise;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            csDly_ff <= 1'b0;
            skDly_ff <= 1'b0;
        end else begin
            csDly_ff <= pins.chipSelect;
            skDly_ff <= pins.serialClock;
        end
    end

    assign csRise = pins.chipSelect & ~csDly_ff;
    assign csFall = ~pins.chipSelect & csDly_ff;
    // serial clock gated by select
    assign skRise = pins.serialClock & ~skDly_ff & pins.chipSelect;

    // storage
    logic [WIDTH-1:0] mem [DEPTH];
    logic [7:0]       prot_ff;
    logic             wrEn_ff;
    logic             protEn_ff;

    // command machine state
    state_t           state_ff,   nxt_state;
    logic [4:0]       cnt_ff,     nxt_cnt;
    logic [1:0]       opc_ff,     nxt_opc;
    logic [7:0]       addr_ff,    nxt_addr;
    logic [15:0]      shift_ff,   nxt_shift;
    cmd_t             cmd_ff,     nxt_cmd;
    logic             out_ff,     nxt_out;
    logic             outEn_ff,   nxt_outEn;
    logic             readLen_ff, nxt_readLen;
    logic             pend_ff,    nxt_pend;
    logic [23:0]      prog_ff,    nxt_prog;
    logic             busy_ff;

    // decode of opcode, msbs and side pins
    function automatic cmd_t decode(input logic [1:0] opc,
                                    input logic [7:0] adr,
                                    input logic       prs,
                                    input logic       pen);
        cmd_t c;
        c = CMD_NONE;
        if (!prs) begin
            case (opc)
                `OPC_READ:  c = CMD_READ;
                `OPC_WRITE: c = pen ? CMD_WRITE : CMD_NONE;
                `OPC_MISC: begin
                    if (adr[7:6] == `MSB_ENABLE && pen)
                        c = CMD_WRITE_ENABLE;
                    else if (adr[7:6] == `MSB_ALL && pen)
                        c = CMD_WRITE_ALL;
                    else if (adr[7:6] == `MSB_DISABLE)
                        c = CMD_WRITE_DISABLE;
                end
                default: c = CMD_NONE;
            endcase
        end else if (opc == `OPC_READ) begin
            c = CMD_PROT_READ;
        end else if (pen) begin
            case (opc)
                `OPC_MISC: begin
                    if (adr[7:6] == `MSB_ENABLE) c = CMD_PROT_ENABLE;
                    else if (adr == `ADDR_ZERO)  c = CMD_PROT_DISABLE;
                end
                `OPC_CLEAR:
                    if (adr == `ADDR_ONES) c = CMD_PROT_CLEAR;
                `OPC_WRITE: c = CMD_PROT_WRITE;
                default:    c = CMD_NONE;
            endcase
        end
        return c;
    endfunction

    logic [1:0] opcNow;
    logic [7:0] addrNow;
    cmd_t       cmdNow;
    assign opcNow  = {opc_ff[0], pins.serialIn};
    assign addrNow = {addr_ff[6:0], pins.serialIn};
    assign cmdNow  = decode(opc_ff, addrNow, pins.protectRegSelect,
                            pins.programEnable);

    // next state of the command machine
    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_opc     = opc_ff;
        nxt_addr    = addr_ff;
        nxt_shift   = shift_ff;
        nxt_cmd     = cmd_ff;
        nxt_out     = out_ff;
        nxt_outEn   = pins.chipSelect;
        nxt_readLen = readLen_ff;
        nxt_pend    = pend_ff;
        nxt_prog    = prog_ff;
        if (prog_ff != 24'h00_0000) nxt_prog = prog_ff - 24'h00_0001;
        if (!pins.chipSelect) begin
            nxt_out = 1'b0;
            nxt_state = ST_IDLE;
            if (csFall && pend_ff) begin
                nxt_prog = 24'(PROG_CYCLES);
                nxt_pend = 1'b0;
            end
        end else if (csRise) begin
            nxt_state = ST_IDLE;
            nxt_cmd   = CMD_NONE;
            nxt_pend  = 1'b0;
            nxt_out   = (prog_ff == 24'h00_0000);
        end else if (prog_ff != 24'h00_0000) begin
            // ready shows without any serial clock once the count expires
            nxt_out = (prog_ff == 24'h00_0001);
        end else if (skRise) begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_out = 1'b1; // ready status until a command
                    if (pins.serialIn) begin
                        nxt_state = ST_OPC;
                        nxt_cnt   = 5'd0;
                    end
                end
                ST_OPC: begin
                    nxt_opc = opcNow;
                    nxt_cnt = cnt_ff + 5'd1;
                    if (cnt_ff == 5'd1) begin
                        nxt_state = ST_ADDR;
                        nxt_cnt   = 5'd0;
                    end
                end
                ST_ADDR: begin
                    nxt_addr = addrNow;
                    nxt_cnt  = cnt_ff + 5'd1;
                    if (cnt_ff == 5'd7) begin
                        nxt_cnt = 5'd0;
                        nxt_cmd = cmdNow;
                        nxt_out = 1'b0;
                        case (cmdNow)
                            CMD_READ: begin
                                nxt_shift   = mem[addrNow];
                                nxt_readLen = 1'b1;
                                nxt_state   = ST_READ;
                            end
                            CMD_PROT_READ: begin
                                nxt_shift   = {prot_ff, 8'h00};
                                nxt_readLen = 1'b0;
                                nxt_state   = ST_READ;
                            end
                            CMD_WRITE, CMD_WRITE_ALL:
                                nxt_state = ST_DATA;
                            CMD_NONE: nxt_state = ST_WAIT;
                            default: begin
                                nxt_pend  = 1'b1;
                                nxt_state = ST_WAIT;
                            end
                        endcase
                    end
                end
                ST_DATA: begin
                    nxt_shift = {shift_ff[14:0], pins.serialIn};
                    nxt_cnt   = cnt_ff + 5'd1;
                    if (cnt_ff == 5'd15) begin
                        nxt_pend  = 1'b1;
                        nxt_state = ST_WAIT;
                    end
                end
                ST_READ: begin
                    nxt_out   = shift_ff[15];
                    nxt_shift = {shift_ff[14:0], 1'b0};
                    nxt_cnt   = cnt_ff + 5'd1;
                    if (readLen_ff && cnt_ff == 5'd15) begin
                        nxt_addr  = addr_ff + 8'h01;
                        nxt_shift = mem[addr_ff + 8'h01];
                        nxt_cnt   = 5'd0;
                    end else if (!readLen_ff && cnt_ff == 5'd7) begin
                        nxt_state = ST_WAIT;
                    end
                end
                default: nxt_state = ST_WAIT;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= 5'd0;
            opc_ff     <= 2'b00;
            addr_ff    <= 8'h00;
            shift_ff   <= 16'h0000;
            cmd_ff     <= CMD_NONE;
            out_ff     <= 1'b0;
            outEn_ff   <= 1'b0;
            readLen_ff <= 1'b0;
            pend_ff    <= 1'b0;
            prog_ff    <= 24'h00_0000;
            busy_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            opc_ff     <= nxt_opc;
            addr_ff    <= nxt_addr;
            shift_ff   <= nxt_shift;
            cmd_ff     <= nxt_cmd;
            out_ff     <= nxt_out;
            outEn_ff   <= nxt_outEn;
            readLen_ff <= nxt_readLen;
            pend_ff    <= nxt_pend;
            prog_ff    <= nxt_prog;
            busy_ff    <= (nxt_prog != 24'h00_0000);
        end
    end

    // effects take place on the deselect edge of a complete command
    logic       doExec;
    logic       nxt_wrEn;
    logic       nxt_protEn;
    logic [7:0] nxt_prot;
    logic       memWr;
    logic       memAll;
    assign doExec = csFall && pend_ff && prog_ff == 24'h00_0000;

    always_comb begin
        nxt_wrEn   = wrEn_ff;
        nxt_protEn = protEn_ff;
        nxt_prot   = prot_ff;
        memWr      = 1'b0;
        memAll     = 1'b0;
        if (doExec) begin
            // protect enable is cleared by any command other than protect enable that executes at deselect
            nxt_protEn = 1'b0;
            case (cmd_ff)
                CMD_WRITE_ENABLE:  nxt_wrEn = 1'b1;
                CMD_WRITE_DISABLE: nxt_wrEn = 1'b0;
                CMD_WRITE:
                    memWr = wrEn_ff && (addr_ff < prot_ff);
                CMD_WRITE_ALL:
                    memAll = wrEn_ff && prot_ff == `PROT_RESET;
                CMD_PROT_ENABLE:   nxt_protEn = wrEn_ff;
                CMD_PROT_CLEAR:
                    if (protEn_ff) nxt_prot = `PROT_RESET;
                CMD_PROT_WRITE:
                    if (protEn_ff) nxt_prot = addr_ff;
                default: nxt_protEn = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrEn_ff   <= 1'b0;
            protEn_ff <= 1'b0;
            prot_ff   <= `PROT_RESET;
        end else begin
            wrEn_ff   <= nxt_wrEn;
            protEn_ff <= nxt_protEn;
            prot_ff   <= nxt_prot;
        end
    end

    // array storage; no reset, contents are arbitrary after power up
    always_ff @(posedge clock) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (memAll || (memWr && addr_ff == 8'(i)))
                mem[i] <= shift_ff;
        end
    end

    assign serialOut   = out_ff;
    assign serialOutEn = outEn_ff;
    assign busy        = busy_ff;

endmodule

// >>> eeprom_port_asserts.sv
/*
 * checker of the eeprom command port: output enable, status, hold and
 * programming time as seen at the top ports.
 * assumes a bind onto serial_eeprom_command_port and its core clock.
 */
`timescale 1ns/10ps

module eeprom_port_asserts
#(
    parameter int PROG_CYCLES = 50
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic chipSelect,
    input wire logic serialClock,
    input wire logic serialIn,
    input wire logic protectRegSelect,
    input wire logic programEnable,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic busy
);
    // busy lasts PROG_CYCLES core cycles; allow two cycles of slack either way
    localparam int LO = PROG_CYCLES - 2;
    localparam int HI = PROG_CYCLES + 2;
    int busyCnt_ff;
    int nxt_busyCnt;

    // length of the current busy stretch
    always_comb begin
        nxt_busyCnt = busy ? busyCnt_ff + 1 : 0;
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busyCnt_ff <= 0;
        end else begin
            busyCnt_ff <= nxt_busyCnt;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // select rises on an idle device and the clock stays low meanwhile
    sequence s_readySel;
        $rose(chipSelect) && !busy ##1
        (chipSelect && !serialClock && !busy)[*5];
    endsequence

    property p_oeOff;
        !chipSelect[*4] |=> !serialOutEn;
    endproperty
    property p_oeOn;
        chipSelect[*5] |=> serialOutEn;
    endproperty
    property p_outDesel;
        !chipSelect[*5] |=> !serialOut;
    endproperty
    property p_busyLen;
        $fell(busy) |-> busyCnt_ff >= LO && busyCnt_ff <= HI;
    endproperty
    property p_busyRise;
        $rose(busy) |-> !chipSelect;
    endproperty
    property p_statusBusy;
        (chipSelect && busy)[*6] |-> !serialOut;
    endproperty
    property p_statusReady;
        s_readySel |-> serialOut;
    endproperty
    property p_outHold;
        (chipSelect && !serialClock && !busy)[*8] |-> $stable(serialOut);
    endproperty

    a_oeOff: assert property (p_oeOff)
        else $error("output enabled while deselected");
    a_oeOn: assert property (p_oeOn)
        else $error("output not enabled while selected");
    a_outDesel: assert property (p_outDesel)
        else $error("serial out active while deselected");
    a_busyLen: assert property (p_busyLen)
        else $error("programming time off");
    a_busyRise: assert property (p_busyRise)
        else $error("programming started while selected");
    a_statusBusy: assert property (p_statusBusy)
        else $error("status not busy during programming");
    a_statusReady: assert property (p_statusReady)
        else $error("status not ready after select");
    a_outHold: assert property (p_outHold)
        else $error("serial out moved without a clock rise");
endmodule

bind serial_eeprom_command_port eeprom_port_asserts #(
    .PROG_CYCLES(PROG_CYCLES)
) u_chk (
    .clock(clock),
    .rst_b(rst_b),
    .chipSelect(chipSelect),
    .serialClock(serialClock),
    .serialIn(serialIn),
    .protectRegSelect(protectRegSelect),
    .programEnable(programEnable),
    .serialOut(serialOut),
    .serialOutEn(serialOutEn),
    .busy(busy)
);

// >>> serial_master.sv
/*
 * behavioural master of the four-wire serial bus plus side pins.
 * assumes the bench core clock; pins change on its falling edge.
 */
`timescale 1ns/10ps

module serial_master (
    input  wire logic clock,
    input  wire logic serialOut,
    output logic      chipSelect,
    output logic      serialClock,
    output logic      serialIn,
    output logic      protectRegSelect,
    output logic      programEnable
);
    // pins idle with select low and clock still
    initial begin
        chipSelect = 0;
        serialClock = 0;
        serialIn = 0;
        protectRegSelect = 0;
        programEnable = 0;
    end

    // one cycle: n bits msb first, a sample of serialOut before each rise
    task automatic frame(input logic pre, input logic pe,
                         input logic [63:0] bits, input int n,
                         output logic [63:0] got);
        got = '0;
        @(negedge clock);
        protectRegSelect = pre;
        programEnable = pe;
        chipSelect = 1;
        repeat (6) @(negedge clock);
        for (int i = n - 1; i >= 0; i--) begin
            serialClock = 0;
            serialIn = bits[i];
            repeat (4) @(negedge clock);
            got = {got[62:0], serialOut};
            serialClock = 1;
            repeat (4) @(negedge clock);
        end
        serialClock = 0;
        repeat (4) @(negedge clock);
        got = {got[62:0], serialOut};
        chipSelect = 0;
        // released line shows the inverse, never a stale bit
        serialIn = ~serialIn;
        repeat (16) @(negedge clock);
    endtask

    // status poll with no serial clock: first look, then the ready level
    task automatic poll(output logic b0, output logic b1);
        @(negedge clock);
        chipSelect = 1;
        repeat (8) @(negedge clock);
        b0 = serialOut;
        for (int k = 0; k < 200 && serialOut !== 1'b1; k++) begin
            @(negedge clock);
        end
        repeat (10) @(negedge clock);
        b1 = serialOut;
        chipSelect = 0;
        repeat (16) @(negedge clock);
    endtask
endmodule

// >>> tb_top.sv
/*
 * self-checking bench of the eeprom command port against a model.
 * assumes a shortened programming time and the serial_master partner.
 */
`timescale 1ns/10ps

module tb_top;
    logic        clock;
    logic        rst_b;
    wire         chipSelect, serialClock, serialIn;
    wire         protectRegSelect, programEnable;
    wire         serialOut, serialOutEn, busy;
    int          nMismatch = 0;
    int          samplesChecked = 0;
    int          cycles = 0;
    logic [15:0] mem[256];
    logic [7:0]  prot;
    bit          wen, armed;
    logic [63:0] got;
    logic        b0, b1;
    logic [7:0]  a;

    serial_eeprom_command_port #(.PROG_CYCLES(50)) dut (
        .clock(clock), .rst_b(rst_b), .chipSelect(chipSelect),
        .serialClock(serialClock), .serialIn(serialIn),
        .protectRegSelect(protectRegSelect),
        .programEnable(programEnable), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .busy(busy));
    serial_master m (
        .clock(clock), .serialOut(serialOut), .chipSelect(chipSelect),
        .serialClock(serialClock), .serialIn(serialIn),
        .protectRegSelect(protectRegSelect),
        .programEnable(programEnable));

    // core clock
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end

    // a run far longer than the sequence below means a hang
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            nMismatch++;
            final_report();
        end
    end

    task automatic final_report();
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one cycle; model takes the effect at deselect, then wait for idle
    task automatic cmd(input logic pre, input logic pe, input logic [1:0] op,
                       input logic [7:0] adr, input logic [15:0] d,
                       input int ext, input int z);
        logic [63:0] bits;
        bit          was;
        int          n;
        n = 11 + ext + z;
        bits = ({53'h0, 1'b1, op, adr} << ext) | {48'h0, d};
        m.frame(pre, pe, bits, n, got);
        check({15'h0, got[n]}, 16'h0001);
        was = armed;
        armed = 0;
        if (!pre) begin
            if (op == 2'b01 && pe && wen && adr < prot) mem[adr] = d;
            if (op == 2'b00 && adr[7:6] == 2'b11 && pe) wen = 1;
            if (op == 2'b00 && adr[7:6] == 2'b01 && pe && wen
                && prot == 8'hff) begin
                foreach (mem[i]) mem[i] = d;
            end
            if (op == 2'b00 && adr[7:6] == 2'b00) wen = 0;
        end else begin
            if (op == 2'b00 && adr[7:6] == 2'b11 && pe && wen) armed = 1;
            if (op == 2'b11 && adr == 8'hff && pe && was) prot = 8'hff;
            if (op == 2'b01 && pe && was) prot = adr;
        end
        for (int k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clock);
    endtask

    // two-word read: dummy zero, first word, next word with wrap
    task automatic rd(input logic [7:0] adr, input int z);
        cmd(0, $urandom % 2, 2'b10, adr, $urandom, 33, z);
        check({15'h0, got[33]}, 16'h0000);
        check(got[32:17], mem[adr]);
        check(got[16:1], mem[adr + 8'h01]);
    endtask

    task automatic prd(input logic [7:0] exp);
        cmd(1, 0, 2'b10, $urandom, $urandom, 33, 0);
        check({15'h0, got[33]}, 16'h0000);
        check({8'h00, got[32:25]}, {8'h00, exp});
    endtask

    initial begin
        void'($urandom(48035));
        rst_b = 0;
        prot = 8'hff;
        wen = 0;
        armed = 0;
        repeat (12) @(negedge clock);
        rst_b = 1;
        // refused before enable: memory stays unknown-free after write-all
        cmd(0, 1, 2'b00, 8'h40, 16'h0000, 16, 0);
        cmd(0, 1, 2'b00, 8'hc0, 0, 0, 0);
        m.frame(0, 1, {47'h0, 1'b1, 2'b00, 8'h40, 16'ha5c3}, 27, got);
        foreach (mem[i]) mem[i] = 16'ha5c3;
        m.poll(b0, b1);
        check({15'h0, b0}, 16'h0000);
        check({15'h0, b1}, 16'h0001);
        cmd(0, 1, 2'b01, 8'h00, $urandom, 16, 0);
        rd(8'hff, 0);
        // random writes, some with program enable low, leading zeros
        for (int i = 0; i < 5; i++) begin
            a = $urandom % 255;
            cmd(0, $urandom % 2, 2'b01, a, $urandom, 16, 0);
            rd(a, $urandom % 4);
        end
        // invalid code and disabled writes change nothing
        cmd(0, 1, 2'b11, 8'h12, 0, 0, 0);
        cmd(0, 0, 2'b00, 8'h3f, 0, 0, 0);
        cmd(0, 1, 2'b01, 8'h10, $urandom, 16, 0);
        rd(8'h10, 1);
        // protect register: write, boundary, clear, disable
        cmd(0, 1, 2'b00, 8'hff, 0, 0, 0);
        cmd(1, 1, 2'b01, 8'h80, 0, 0, 0);
        prd(8'hff);
        cmd(1, 1, 2'b00, 8'hc3, 0, 0, 0);
        cmd(1, 1, 2'b01, 8'h80, 0, 0, 0);
        prd(8'h80);
        cmd(0, 1, 2'b01, 8'h80, $urandom, 16, 0);
        cmd(0, 1, 2'b01, 8'h7f, $urandom, 16, 0);
        rd(8'h7f, 0);
        cmd(0, 1, 2'b00, 8'h40, $urandom, 16, 0);
        rd(8'h05, 0);
        cmd(1, 1, 2'b00, 8'hc0, 0, 0, 0);
        cmd(1, 0, 2'b11, 8'hff, 0, 0, 0);
        prd(8'h80);
        cmd(1, 1, 2'b00, 8'hc0, 0, 0, 0);
        cmd(1, 1, 2'b11, 8'hff, 0, 0, 0);
        prd(8'hff);
        cmd(1, 1, 2'b00, 8'hc0, 0, 0, 0);
        cmd(1, 1, 2'b00, 8'h00, 0, 0, 0);
        prd(8'hff);
        final_report();
    end
endmodule
